// ===== rtl/cwr_pkg.sv
// Package: register map, field positions and reset values for the write bank
package cwr_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_ENC_CTRL2 = 5'h07;
  localparam logic [4:0] ADDR_SYNC_LEN = 5'h08;
  localparam logic [4:0] ADDR_SYNC_THR = 5'h09;
  localparam logic [4:0] ADDR_ERR_LOW = 5'h0A;
  localparam logic [4:0] ADDR_ERR_MID = 5'h0B;
  localparam logic [4:0] ADDR_ERR_HIGH = 5'h0C;
  localparam logic [4:0] ADDR_DEC_IN_STB = 5'h0E;
  localparam logic [4:0] ADDR_DEC_OUT_STB = 5'h0F;
  localparam logic [4:0] ADDR_ENC_IN_STB = 5'h11;
  localparam logic [4:0] ADDR_ENC_OUT_STB = 5'h12;
  localparam logic [4:0] ADDR_ENC_DATA = 5'h05;
  localparam logic [4:0] ADDR_NORM_ENA = 5'h17;
  localparam logic [4:0] ADDR_BER_ENA = 5'h18;
  localparam int BIT_PORT_SEL = 3;
  localparam int BIT_DIFF_ENC = 4;
  localparam int BIT_WHITEN = 5;
  localparam int BIT_VARIANT = 6;
  localparam int BIT_ENC_DATA = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [23:0] RST_WINDOW = 24'h000000;
  localparam int STROBE_CYCLES = 1;
endpackage : cwr_pkg

// ===== rtl/cwr_strobe.sv
// One-cycle high pulse generator, ORed with its pin clock
`timescale 1ns/100ps
module cwr_strobe
  import cwr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic fire,
  input wire logic pin_clock,
  output logic clock_out
);
  logic out_reg;
  logic out_next;

  // Registered so the core clock never carries decode glitches
  always_comb begin
    out_next = pin_clock | fire;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
    end
  end

  assign clock_out = out_reg;
endmodule : cwr_strobe

// ===== rtl/cwr_bank.sv
// Write-only register bank of the encoder/decoder processor interface
// How it works
// - Port select one routes encoder bit input and symbols via processor bus.
// - Port select zero uses the dedicated encoder pins for input and symbols.
// - Port select switches only encoder bit input and the three symbol outputs.
// - Differential encode bit turns the differential encoder on or off.
// - Differential encode bit never touches the differential decoder.
// - Whitening bit enables the scrambler ahead of the encoder, else bypass.
// - Whitening bit leaves the decoder-side descrambler alone.
// - Variant one with whitening on selects the exact standard scrambler.
// - Variant zero with whitening on selects the modified scrambler.
// - Eight-bit monitor length count, bit 0 least significant.
// - Eight-bit normalize threshold count, bit 0 least significant.
// - Error-rate window is 24 bits written low, middle, high byte.
// - Any write to decoder input strobe gives one symbol input clock.
// - Any write to decoder output strobe gives one data output clock.
// - Any write to encoder input strobe gives one data input clock.
// - Any write to encoder output strobe gives one symbol output clock.
// - Normalize enable write applies counts and restarts the sync monitor.
// - Error-rate enable write applies the window and restarts the test.
`timescale 1ns/100ps
module cwr_bank
  import cwr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic [4:0] addr,
  input wire logic [7:0] data_in,
  input wire logic encoder_bit_input,
  input wire logic encoded_symbol_first,
  input wire logic encoded_symbol_second,
  input wire logic encoded_symbol_third,
  input wire logic pin_decoder_symbol_in_clock,
  input wire logic pin_decoder_data_out_clock,
  input wire logic pin_encoder_data_in_clock,
  input wire logic pin_encoder_symbol_out_clock,
  output logic core_encoder_bit,
  output logic [2:0] pin_symbols_out,
  output logic [2:0] bus_symbols,
  output logic port_select,
  output logic differential_encode_enable,
  output logic whitening_enable,
  output logic whitening_variant_select,
  output logic [7:0] sync_length,
  output logic [7:0] sync_threshold,
  output logic sync_restart,
  output logic [23:0] error_rate_window,
  output logic error_rate_restart,
  output logic decoder_symbol_in_clock,
  output logic decoder_data_out_clock,
  output logic encoder_data_in_clock,
  output logic encoder_symbol_out_clock
);
  logic wr_prev_reg;
  logic wr_prev_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] len_ld_reg;
  logic [7:0] len_ld_next;
  logic [7:0] thr_ld_reg;
  logic [7:0] thr_ld_next;
  logic [23:0] win_ld_reg;
  logic [23:0] win_ld_next;
  logic [7:0] len_reg;
  logic [7:0] len_next;
  logic [7:0] thr_reg;
  logic [7:0] thr_next;
  logic [23:0] win_reg;
  logic [23:0] win_next;
  logic sync_rs_reg;
  logic sync_rs_next;
  logic err_rs_reg;
  logic err_rs_next;
  logic bus_bit_reg;
  logic bus_bit_next;
  logic core_bit_reg;
  logic core_bit_next;
  logic [2:0] pin_sym_reg;
  logic [2:0] pin_sym_next;
  logic [2:0] bus_sym_reg;
  logic [2:0] bus_sym_next;
  logic wr_pulse;
  logic [3:0] fire;
  logic [2:0] core_sym;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] target);
    return a == target;
  endfunction : hit

  // Act once per strobe on the falling edge of the active-low write
  assign wr_pulse = !cs_n && !wr_n && wr_prev_reg;
  assign core_sym = {encoded_symbol_third, encoded_symbol_second, encoded_symbol_first};

  always_comb begin
    wr_prev_next = cs_n | wr_n;
    ctrl_next = ctrl_reg;
    len_ld_next = len_ld_reg;
    thr_ld_next = thr_ld_reg;
    win_ld_next = win_ld_reg;
    len_next = len_reg;
    thr_next = thr_reg;
    win_next = win_reg;
    sync_rs_next = 1'b0;
    err_rs_next = 1'b0;
    bus_bit_next = bus_bit_reg;
    fire = 4'h0;
    if (wr_pulse) begin
      // Reserved bits stored as written; the core ignores them
      if (hit(addr, ADDR_ENC_CTRL2)) ctrl_next = data_in;
      if (hit(addr, ADDR_SYNC_LEN)) len_ld_next = data_in;
      if (hit(addr, ADDR_SYNC_THR)) thr_ld_next = data_in;
      if (hit(addr, ADDR_ERR_LOW)) win_ld_next[7:0] = data_in;
      if (hit(addr, ADDR_ERR_MID)) win_ld_next[15:8] = data_in;
      if (hit(addr, ADDR_ERR_HIGH)) win_ld_next[23:16] = data_in;
      if (hit(addr, ADDR_ENC_DATA)) bus_bit_next = data_in[BIT_ENC_DATA];
      // Loaded values take effect only on the enable write
      if (hit(addr, ADDR_NORM_ENA)) begin
        len_next = len_ld_reg;
        thr_next = thr_ld_reg;
        sync_rs_next = 1'b1;
      end
      if (hit(addr, ADDR_BER_ENA)) begin
        win_next = win_ld_reg;
        err_rs_next = 1'b1;
      end
      fire[0] = hit(addr, ADDR_DEC_IN_STB);
      fire[1] = hit(addr, ADDR_DEC_OUT_STB);
      fire[2] = hit(addr, ADDR_ENC_IN_STB);
      fire[3] = hit(addr, ADDR_ENC_OUT_STB);
    end
    // Only the bit input and the three symbols move with port select
    core_bit_next = ctrl_reg[BIT_PORT_SEL] ? bus_bit_reg : encoder_bit_input;
    pin_sym_next = ctrl_reg[BIT_PORT_SEL] ? 3'h0 : core_sym;
    bus_sym_next = ctrl_reg[BIT_PORT_SEL] ? core_sym : bus_sym_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_prev_reg <= 1'b1;
      ctrl_reg <= RST_BYTE;
      len_ld_reg <= RST_BYTE;
      thr_ld_reg <= RST_BYTE;
      win_ld_reg <= RST_WINDOW;
      len_reg <= RST_BYTE;
      thr_reg <= RST_BYTE;
      win_reg <= RST_WINDOW;
      sync_rs_reg <= 1'b0;
      err_rs_reg <= 1'b0;
      bus_bit_reg <= 1'b0;
      core_bit_reg <= 1'b0;
      pin_sym_reg <= 3'h0;
      bus_sym_reg <= 3'h0;
    end else begin
      wr_prev_reg <= wr_prev_next;
      ctrl_reg <= ctrl_next;
      len_ld_reg <= len_ld_next;
      thr_ld_reg <= thr_ld_next;
      win_ld_reg <= win_ld_next;
      len_reg <= len_next;
      thr_reg <= thr_next;
      win_reg <= win_next;
      sync_rs_reg <= sync_rs_next;
      err_rs_reg <= err_rs_next;
      bus_bit_reg <= bus_bit_next;
      core_bit_reg <= core_bit_next;
      pin_sym_reg <= pin_sym_next;
      bus_sym_reg <= bus_sym_next;
    end
  end

  // Pin must idle low while strobes drive the clock; OR merges both
  cwr_strobe u_dec_in (
    .clk(clk), .rst(rst), .fire(fire[0]),
    .pin_clock(pin_decoder_symbol_in_clock), .clock_out(decoder_symbol_in_clock)
  );
  cwr_strobe u_dec_out (
    .clk(clk), .rst(rst), .fire(fire[1]),
    .pin_clock(pin_decoder_data_out_clock), .clock_out(decoder_data_out_clock)
  );
  cwr_strobe u_enc_in (
    .clk(clk), .rst(rst), .fire(fire[2]),
    .pin_clock(pin_encoder_data_in_clock), .clock_out(encoder_data_in_clock)
  );
  cwr_strobe u_enc_out (
    .clk(clk), .rst(rst), .fire(fire[3]),
    .pin_clock(pin_encoder_symbol_out_clock), .clock_out(encoder_symbol_out_clock)
  );

  assign core_encoder_bit = core_bit_reg;
  assign pin_symbols_out = pin_sym_reg;
  assign bus_symbols = bus_sym_reg;
  assign port_select = ctrl_reg[BIT_PORT_SEL];
  // Encoder-side only; decoder controls live elsewhere
  assign differential_encode_enable = ctrl_reg[BIT_DIFF_ENC];
  assign whitening_enable = ctrl_reg[BIT_WHITEN];
  assign whitening_variant_select = ctrl_reg[BIT_VARIANT];
  assign sync_length = len_reg;
  assign sync_threshold = thr_reg;
  assign sync_restart = sync_rs_reg;
  assign error_rate_window = win_reg;
  assign error_rate_restart = err_rs_reg;
endmodule : cwr_bank

// ===== dv/cwr_bank_props.sv
// Port-level assertions for the write register bank
`timescale 1ns/100ps
module cwr_bank_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic [4:0] addr,
  input wire logic [7:0] data_in,
  input wire logic port_select,
  input wire logic differential_encode_enable,
  input wire logic whitening_enable,
  input wire logic whitening_variant_select,
  input wire logic [7:0] sync_length,
  input wire logic sync_restart,
  input wire logic [23:0] error_rate_window,
  input wire logic error_rate_restart,
  input wire logic decoder_symbol_in_clock,
  input wire logic decoder_data_out_clock,
  input wire logic encoder_data_in_clock,
  input wire logic encoder_symbol_out_clock
);
  logic idle_reg;
  logic take;
  logic a17;
  logic a18;
  // One action per strobe: low level only counts on its first cycle
  always_ff @(posedge clk) idle_reg <= rst | cs_n | wr_n;
  assign take = !cs_n && !wr_n && idle_reg;
  assign a17 = take && addr == 5'h17;
  assign a18 = take && addr == 5'h18;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ctrl_bits_a: assert property (take && addr == 5'h07 |=>
    {whitening_variant_select, whitening_enable, differential_encode_enable, port_select}
    == $past(data_in[6:3])) else $error("control bits wrong");
  length_hold_a: assert property ($changed(sync_length) |->
    $past(a17) || $past(a17, 2)) else $error("length changed without apply");
  window_hold_a: assert property ($changed(error_rate_window) |->
    $past(a18) || $past(a18, 2)) else $error("window changed without apply");
  norm_pulse_a: assert property (a17 |-> ##[1:2] sync_restart)
    else $error("no sync restart");
  rate_pulse_a: assert property (a18 |-> ##[1:2] error_rate_restart ##1 !error_rate_restart)
    else $error("bad rate restart");
  dec_in_a: assert property (take && addr == 5'h0E |-> ##[1:2] decoder_symbol_in_clock)
    else $error("no decoder input clock");
  dec_out_a: assert property (take && addr == 5'h0F |-> ##[1:2] decoder_data_out_clock)
    else $error("no decoder output clock");
  enc_in_a: assert property (take && addr == 5'h11 |-> ##[1:2] encoder_data_in_clock)
    else $error("no encoder input clock");
  enc_out_a: assert property (take && addr == 5'h12 |-> ##[1:2] encoder_symbol_out_clock)
    else $error("no encoder output clock");
endmodule : cwr_bank_props
bind cwr_bank cwr_bank_props cwr_bank_props_i (.*);

// ===== dv/cwr_cpu.sv
// Processor model driving the write strobe bus
`timescale 1ns/100ps
module cwr_cpu (
  input wire logic clk,
  output logic cs_n,
  output logic wr_n,
  output logic [4:0] addr,
  output logic [7:0] data_in
);
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    addr = 5'h1F;
    data_in = 8'h00;
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input int len = 1);
    @(negedge clk);
    cs_n = 1'b0;
    wr_n = 1'b0;
    addr = a;
    data_in = d;
    // A longer low strobe must still act only once
    repeat (len) @(negedge clk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    addr = ~a;
    // Released bus shows no stale byte
    data_in = ~d;
    @(negedge clk);
  endtask : wr
endmodule : cwr_cpu

// ===== dv/testbench.sv
// Self-checking bench for the write register bank
`timescale 1ns/100ps
module testbench;
  import cwr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, wr_n, encoder_bit_input, core_encoder_bit, port_select, sync_restart;
  logic differential_encode_enable, whitening_enable, whitening_variant_select;
  logic encoded_symbol_first, encoded_symbol_second, encoded_symbol_third;
  logic pin_decoder_symbol_in_clock, pin_decoder_data_out_clock, pin_encoder_data_in_clock;
  logic pin_encoder_symbol_out_clock, decoder_symbol_in_clock, decoder_data_out_clock;
  logic encoder_data_in_clock, encoder_symbol_out_clock, error_rate_restart;
  logic [4:0] addr;
  logic [7:0] data_in, sync_length, sync_threshold;
  logic [2:0] pin_symbols_out, bus_symbols;
  logic [23:0] error_rate_window;
  logic [3:0] ctrl;
  logic [5:0] ev;
  int cnt [6];
  int b0;
  int n_fail = 0;
  int num_checks = 0;
  logic [11:0] rows [6] = '{12'h081, 12'h102, 12'h204, 12'h408, 12'h78F, 12'h000};
  always #5 clk = ~clk;
  assign ctrl = {whitening_variant_select, whitening_enable, differential_encode_enable,
    port_select};
  assign ev = {sync_restart, error_rate_restart, decoder_symbol_in_clock,
    decoder_data_out_clock, encoder_data_in_clock, encoder_symbol_out_clock};
  always @(posedge clk) for (int i = 0; i < 6; i++) cnt[i] += ev[i];
  cwr_cpu cwr_cpu_i (.*);
  cwr_bank cwr_bank_i (.*);
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Every write also proves no stray pulse appears elsewhere
  task automatic w(input logic [4:0] a, input logic [7:0] d, input logic [5:0] m,
      input int len = 1);
    int b [6];
    b = cnt;
    cwr_cpu_i.wr(a, d, len);
    @(negedge clk);
    for (int i = 0; i < 6; i++) chk("pulses", 24'(cnt[i] - b[i]), 24'(m[i]));
  endtask : w
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    #20000;
    n_fail++;
    give_verdict;
  end
  initial begin
    {encoder_bit_input, encoded_symbol_first, encoded_symbol_second, encoded_symbol_third} = 4'h0;
    {pin_decoder_symbol_in_clock, pin_decoder_data_out_clock, pin_encoder_data_in_clock,
      pin_encoder_symbol_out_clock} = 4'h0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk("reset", 24'({ctrl, sync_length, sync_threshold[3:0]}), 24'h0);
    for (int i = 0; i < 6; i++) begin
      w(ADDR_ENC_CTRL2, rows[i][11:4], 6'h00);
      chk("ctrl", 24'(ctrl), 24'(rows[i][3:0]));
    end
    w(5'h0D, 8'hFF, 6'h00);
    chk("unmapped", 24'(ctrl), 24'h0);
    $display("control rows done");
    w(ADDR_SYNC_LEN, 8'h5A, 6'h00);
    w(ADDR_SYNC_THR, 8'hC3, 6'h00);
    w(ADDR_ERR_LOW, 8'h11, 6'h00);
    w(ADDR_ERR_MID, 8'h22, 6'h00);
    w(ADDR_ERR_HIGH, 8'h33, 6'h00);
    chk("early", {sync_length, error_rate_window[15:0]}, 24'h0);
    w(ADDR_NORM_ENA, 8'h00, 6'h20);
    chk("counts", 24'({sync_threshold, sync_length}), 24'hC35A);
    w(ADDR_BER_ENA, 8'hFF, 6'h10);
    chk("window", error_rate_window, 24'h332211);
    w(ADDR_DEC_IN_STB, 8'h00, 6'h08);
    w(ADDR_DEC_IN_STB, 8'h3C, 6'h08, 4);
    w(ADDR_DEC_OUT_STB, 8'hFF, 6'h04);
    w(ADDR_ENC_IN_STB, 8'h5A, 6'h02);
    w(ADDR_ENC_OUT_STB, 8'hA5, 6'h01);
    b0 = cnt[0];
    pin_encoder_symbol_out_clock = 1'b1;
    repeat (2) @(negedge clk);
    pin_encoder_symbol_out_clock = 1'b0;
    repeat (2) @(negedge clk);
    chk("pin clock", 24'(cnt[0] - b0), 24'h2);
    $display("counts and strobes done");
    encoder_bit_input = 1'b1;
    {encoded_symbol_first, encoded_symbol_second, encoded_symbol_third} = 3'h7;
    repeat (2) @(negedge clk);
    chk("pin mode", 24'({core_encoder_bit, pin_symbols_out}), 24'hF);
    w(ADDR_ENC_CTRL2, 8'h08, 6'h00);
    encoder_bit_input = 1'b0;
    w(ADDR_ENC_DATA, 8'h01, 6'h00);
    chk("bus mode", 24'({core_encoder_bit, pin_symbols_out, bus_symbols}), 24'h47);
    $display("port select done");
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk("reset", 24'({ctrl, sync_length, sync_threshold[3:0]}), 24'h0);
    $display("mid-run reset done");
    give_verdict;
  end
endmodule : testbench
